// ### src/tcsi_channel_status.sv
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module tcsi_channel_status (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [tcsi_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [tcsi_pkg::DATA_W-1:0] wb_dat_i,
    output logic [tcsi_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Event pulses from the counter logic
    input wire logic overflowEvt,
    input wire logic compareAEvt,
    input wire logic compareBEvt,
    input wire logic compareCEvt,
    input wire logic captureALoad,
    input wire logic captureBLoad,
    input wire logic captureARead,
    input wire logic captureBRead,
    input wire logic triggerEvt,
    // Live channel state
    input wire logic clockOn,
    input wire logic lineAPin,
    input wire logic lineBPin,
    input wire logic lineADrive,
    input wire logic lineBDrive,
    // To the counter logic and interrupt controller
    output logic [tcsi_pkg::VAL_W-1:0] compareCValue,
    output logic waveMode,
    output logic irq
);
    import tcsi_pkg::*;

    typedef struct packed {
        logic [VAL_W-1:0] cmpC;
        logic [EVT_W-1:0] flags;
        logic [EVT_W-1:0] mask;
        logic wave;
        logic clkOn;
        logic mirA;
        logic mirB;
        logic pendA;
        logic pendB;
        logic ack;
        logic [DATA_W-1:0] rdData;
        logic irq;
    } tcsi_state_t;

    tcsi_state_t state_ff;
    tcsi_state_t nxt_state;

    logic [1:0] pinSync;
    logic access;
    logic wrStrobe;
    logic rdStrobe;
    logic hitMode;
    logic hitCmpC;
    logic hitStatus;
    logic hitSet;
    logic hitClr;
    logic hitMask;
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] modeKeep;
    logic [EVT_W-1:0] visible;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] readMux;
    logic overrunA;
    logic overrunB;

    // Pins come from outside the clock domain
    tcsi_sync2 #(
        .WIDTH(SYNC_STAGES)
    ) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn({lineBPin, lineAPin}),
        .syncOut(pinSync)
    );

    // One access per request; ack in the cycle after the strobe
    assign access = wb_cyc_i && wb_stb_i && !state_ff.ack;
    assign wrStrobe = access && wb_we_i;
    assign rdStrobe = access && !wb_we_i;

    always_comb begin
        hitMode = 1'b0;
        hitCmpC = 1'b0;
        hitStatus = 1'b0;
        hitSet = 1'b0;
        hitClr = 1'b0;
        hitMask = 1'b0;
        if (wb_adr_i == OFS_MODE) begin
            hitMode = 1'b1;
        end else if (wb_adr_i == OFS_CMPC) begin
            hitCmpC = 1'b1;
        end else if (wb_adr_i == OFS_STATUS) begin
            hitStatus = 1'b1;
        end else if (wb_adr_i == OFS_IRQ_SET) begin
            hitSet = 1'b1;
        end else if (wb_adr_i == OFS_IRQ_CLR) begin
            hitClr = 1'b1;
        end else if (wb_adr_i == OFS_IRQ_MASK) begin
            hitMask = 1'b1;
        end
    end

    // Flags that the present mode lets live
    always_comb begin
        if (state_ff.wave) begin
            modeKeep = ~CAPTURE_ONLY;
        end else begin
            modeKeep = ~WAVE_ONLY;
        end
    end

    // Second load with the first still unread is an overrun
    assign overrunA = captureALoad && state_ff.pendA && !captureARead;
    assign overrunB = captureBLoad && state_ff.pendB && !captureBRead;

    always_comb begin
        events = '0;
        events[BIT_OVF] = overflowEvt;
        events[BIT_LOVR] = overrunA || overrunB;
        events[BIT_CMPA] = compareAEvt;
        events[BIT_CMPB] = compareBEvt;
        events[BIT_CMPC] = compareCEvt;
        events[BIT_CAPA] = captureALoad;
        events[BIT_CAPB] = captureBLoad;
        events[BIT_TRIG] = triggerEvt;
        events = events & modeKeep;
    end

    // Stale flags of the other mode stay hidden
    assign visible = state_ff.flags & modeKeep;

    always_comb begin
        statusWord = '0;
        statusWord[EVT_W-1:0] = visible;
        statusWord[BIT_CLKON] = state_ff.clkOn;
        statusWord[BIT_MIRA] = state_ff.mirA;
        statusWord[BIT_MIRB] = state_ff.mirB;
    end

    always_comb begin
        readMux = '0;
        if (hitMode) begin
            readMux[BIT_WAVE] = state_ff.wave;
        end else if (hitCmpC) begin
            readMux[VAL_W-1:0] = state_ff.cmpC;
        end else if (hitStatus) begin
            readMux = statusWord;
        end else if (hitMask) begin
            readMux[EVT_W-1:0] = state_ff.mask;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.ack = access;
        nxt_state.rdData = state_ff.rdData;
        if (rdStrobe) begin
            nxt_state.rdData = readMux;
        end

        // Mode bit
        if (wrStrobe && hitMode && wb_sel_i[0]) begin
            nxt_state.wave = wb_dat_i[BIT_WAVE];
        end

        // Compare-C, byte lanes honoured
        if (wrStrobe && hitCmpC) begin
            if (wb_sel_i[0]) begin
                nxt_state.cmpC[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                nxt_state.cmpC[15:8] = wb_dat_i[15:8];
            end
        end

        // Mask set and clear ports
        if (wrStrobe && hitSet && wb_sel_i[0]) begin
            nxt_state.mask = state_ff.mask | wb_dat_i[EVT_W-1:0];
        end else if (wrStrobe && hitClr && wb_sel_i[0]) begin
            nxt_state.mask = state_ff.mask & ~wb_dat_i[EVT_W-1:0];
        end

        // Read clears, a same-cycle event still sets
        if (rdStrobe && hitStatus) begin
            nxt_state.flags = events;
        end else begin
            nxt_state.flags = state_ff.flags | events;
        end

        // Unread capture tracking
        if (captureALoad) begin
            nxt_state.pendA = 1'b1;
        end else if (captureARead) begin
            nxt_state.pendA = 1'b0;
        end
        if (captureBLoad) begin
            nxt_state.pendB = 1'b1;
        end else if (captureBRead) begin
            nxt_state.pendB = 1'b0;
        end

        // Live views, never cleared by a read
        nxt_state.clkOn = clockOn;
        if (state_ff.wave) begin
            nxt_state.mirA = lineADrive;
            nxt_state.mirB = lineBDrive;
        end else begin
            nxt_state.mirA = pinSync[0];
            nxt_state.mirB = pinSync[1];
        end

        // Level interrupt follows the next flag and mask values
        nxt_state.irq = |(nxt_state.flags & modeKeep & nxt_state.mask);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff.cmpC <= RST_CMPC;
            state_ff.flags <= RST_STATUS;
            state_ff.mask <= RST_MASK;
            state_ff.wave <= RST_WAVE;
            state_ff.clkOn <= 1'b0;
            state_ff.mirA <= 1'b0;
            state_ff.mirB <= 1'b0;
            state_ff.pendA <= 1'b0;
            state_ff.pendB <= 1'b0;
            state_ff.ack <= 1'b0;
            state_ff.rdData <= '0;
            state_ff.irq <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wb_dat_o = state_ff.rdData;
    assign wb_ack_o = state_ff.ack;
    assign compareCValue = state_ff.cmpC;
    assign waveMode = state_ff.wave;
    assign irq = state_ff.irq;
endmodule : tcsi_channel_status

// ### src/tcsi_pkg.sv
package tcsi_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EVT_W = 8;
    localparam int VAL_W = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CMPC = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_SET = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h2c;

    // Status and mode field positions
    localparam int BIT_OVF = 0;
    localparam int BIT_LOVR = 1;
    localparam int BIT_CMPA = 2;
    localparam int BIT_CMPB = 3;
    localparam int BIT_CMPC = 4;
    localparam int BIT_CAPA = 5;
    localparam int BIT_CAPB = 6;
    localparam int BIT_TRIG = 7;
    localparam int BIT_CLKON = 16;
    localparam int BIT_MIRA = 17;
    localparam int BIT_MIRB = 18;
    localparam int BIT_WAVE = 0;

    // Flags alive only in one mode
    localparam logic [EVT_W-1:0] CAPTURE_ONLY = 8'h62;
    localparam logic [EVT_W-1:0] WAVE_ONLY = 8'h0c;

    // Reset values and pin synchronizer width
    localparam logic [VAL_W-1:0] RST_CMPC = 16'h0000;
    localparam logic [EVT_W-1:0] RST_STATUS = 8'h00;
    localparam logic [EVT_W-1:0] RST_MASK = 8'h00;
    localparam logic RST_WAVE = 1'b0;
    localparam int SYNC_STAGES = 2;
endpackage : tcsi_pkg

// ### src/tcsi_sync2.sv
`timescale 1ns/1ps
module tcsi_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Asynchronous levels in, settled levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import tcsi_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] safe;
    } tcsi_sync_t;

    tcsi_sync_t state_ff;
    tcsi_sync_t nxt_state;

    // First stage feeds only the second one
    always_comb begin
        nxt_state.meta = asyncIn;
        nxt_state.safe = state_ff.meta;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign syncOut = state_ff.safe;
endmodule : tcsi_sync2

// ### testbench/tcsi_checker.sv
`timescale 1ns/1ps
module tcsi_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bus
    input wire logic wb_we_i,
    input wire logic [tcsi_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [tcsi_pkg::DATA_W-1:0] wb_dat_i,
    input wire logic [tcsi_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Events and state
    input wire logic overflowEvt,
    input wire logic compareAEvt,
    input wire logic compareCEvt,
    input wire logic captureALoad,
    input wire logic triggerEvt,
    input wire logic clockOn,
    input wire logic [tcsi_pkg::VAL_W-1:0] compareCValue,
    input wire logic waveMode,
    input wire logic irq
);
    import tcsi_pkg::*;
    logic stRd;
    // Read data is only meaningful in the ack cycle
    assign stRd = wb_ack_o && !wb_we_i && wb_adr_i == OFS_STATUS;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ovf_flag_read_a:
        assert property (stRd && $past(overflowEvt, 2) |-> wb_dat_o[BIT_OVF])
        else $error("overflow flag missing");
    cmpc_flag_read_a:
        assert property (stRd && $past(compareCEvt, 2) |-> wb_dat_o[BIT_CMPC])
        else $error("compare C flag missing");
    trig_flag_read_a:
        assert property (stRd && $past(triggerEvt, 2) |-> wb_dat_o[BIT_TRIG])
        else $error("trigger flag missing");
    capa_flag_read_a:
        assert property (stRd && $past(captureALoad, 2) && !$past(waveMode, 2)
            && !$past(waveMode) |-> wb_dat_o[BIT_CAPA])
        else $error("capture A flag missing");
    cmpa_flag_read_a:
        assert property (stRd && $past(compareAEvt, 2) && $past(waveMode, 2)
            && $past(waveMode) |-> wb_dat_o[BIT_CMPA])
        else $error("compare A flag missing");
    mode_gate_a:
        assert property (stRd |-> (wb_dat_o[EVT_W-1:0] & ($past(waveMode) ?
            CAPTURE_ONLY : WAVE_ONLY)) == '0)
        else $error("flag of other mode visible");
    reserved_zero_a:
        assert property (stRd |-> wb_dat_o[15:8] == '0 && wb_dat_o[31:19] == '0)
        else $error("reserved status bits set");
    clk_state_a:
        assert property (stRd |-> wb_dat_o[BIT_CLKON] == $past(clockOn, 2))
        else $error("clock state bit wrong");
    cmpc_write_a:
        assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_CMPC &&
            wb_sel_i == 4'hf |-> compareCValue == wb_dat_i[VAL_W-1:0])
        else $error("compare C write lost");
    irq_disable_a:
        assert property (wb_ack_o && wb_we_i && wb_adr_i == OFS_IRQ_CLR &&
            wb_dat_i[7:0] == 8'hff |-> !irq)
        else $error("irq after full disable");
    cover property (stRd && wb_dat_o[BIT_LOVR]);
    cover property (irq);
    cover property (stRd && waveMode);
endmodule : tcsi_checker

bind tcsi_channel_status tcsi_checker chk (.clk(clk), .resetn(resetn),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .overflowEvt(overflowEvt), .compareAEvt(compareAEvt),
    .compareCEvt(compareCEvt), .captureALoad(captureALoad),
    .triggerEvt(triggerEvt), .clockOn(clockOn),
    .compareCValue(compareCValue), .waveMode(waveMode), .irq(irq));

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tcsi_pkg::*;
    logic clk, resetn, cyc, we, ack, clockOn, waveMode, irq;
    logic [7:0] adr;
    logic [31:0] datI, datO, rd;
    // ovf, cmpA, cmpB, cmpC, capA, capB, rdA, rdB, trg
    logic [8:0] ev;
    logic [1:0] pin, drv;
    logic [15:0] cmpC;
    int nMismatch, checksDone, tick;

    tcsi_channel_status uut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
        .overflowEvt(ev[0]), .compareAEvt(ev[1]), .compareBEvt(ev[2]),
        .compareCEvt(ev[3]), .captureALoad(ev[4]), .captureBLoad(ev[5]),
        .captureARead(ev[6]), .captureBRead(ev[7]), .triggerEvt(ev[8]),
        .clockOn(clockOn), .lineAPin(pin[0]), .lineBPin(pin[1]),
        .lineADrive(drv[0]), .lineBDrive(drv[1]), .compareCValue(cmpC),
        .waveMode(waveMode), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stopTest();
        $display("mismatches %0d checks %0d", nMismatch, checksDone);
        if (nMismatch == 0 && checksDone > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stopTest

    always @(posedge clk) begin
        tick++;
        if (tick == 5000) begin
            nMismatch++;
            stopTest();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Events in e land in the cycle the request is taken
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [8:0] e);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        datI <= d;
        ev <= e;
        @(posedge clk);
        ev <= 9'h000;
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rd = datO;
        cyc <= 1'b0;
        if (n == 20)
            nMismatch++;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 9'h000);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 9'h000);
        chk(rd, exp);
    endtask : rdChk

    // Left high until the next transfer clears it
    task automatic pulse(input logic [8:0] e);
        @(posedge clk);
        ev <= e;
    endtask : pulse

    task automatic tRegs();
        rdChk(OFS_CMPC, 32'h0);
        rdChk(OFS_STATUS, 32'h0);
        rdChk(OFS_IRQ_MASK, 32'h0);
        rdChk(8'h30, 32'h0);
        wr(OFS_CMPC, 32'hffff_a5c3);
        chk({16'h0, cmpC}, 32'h0000_a5c3);
        rdChk(OFS_CMPC, 32'h0000_a5c3);
        wr(OFS_IRQ_MASK, 32'hffff_ffff);
        rdChk(OFS_IRQ_MASK, 32'h0);
    endtask : tRegs

    task automatic tFlags();
        pulse(9'h13f);
        rdChk(OFS_STATUS, 32'h0000_00f1);
        rdChk(OFS_STATUS, 32'h0);
        wr(OFS_MODE, 32'h1);
        chk({31'h0, waveMode}, 32'h1);
        pulse(9'h13f);
        rdChk(OFS_STATUS, 32'h0000_009d);
        wr(OFS_MODE, 32'h0);
        pulse(9'h010);
        pulse(9'h010);
        rdChk(OFS_STATUS, 32'h0000_0022);
        // A load still pends here, so read it before the next load
        pulse(9'h040);
        pulse(9'h010);
        rdChk(OFS_STATUS, 32'h0000_0020);
    endtask : tFlags

    task automatic tMirror();
        @(posedge clk);
        clockOn <= 1'b1;
        pin <= 2'b01;
        drv <= 2'b10;
        repeat (3) @(posedge clk);
        rdChk(OFS_STATUS, 32'h0003_0000);
        wr(OFS_MODE, 32'h1);
        rdChk(OFS_STATUS, 32'h0005_0000);
        wr(OFS_MODE, 32'h0);
    endtask : tMirror

    task automatic tIrq();
        wr(OFS_IRQ_SET, 32'h0000_0011);
        rdChk(OFS_IRQ_MASK, 32'h0000_0011);
        pulse(9'h001);
        @(posedge clk);
        ev <= 9'h000;
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_CLR, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        rdChk(OFS_IRQ_MASK, 32'h0000_0010);
        wr(OFS_IRQ_SET, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        rdChk(OFS_STATUS, 32'h0003_0001);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_CLR, 32'h0000_00ff);
        rdChk(OFS_IRQ_MASK, 32'h0);
        // Trigger lands in the clearing read cycle
        xfer(1'b0, OFS_STATUS, 32'h0, 9'h100);
        chk(rd, 32'h0003_0000);
        rdChk(OFS_STATUS, 32'h0003_0080);
    endtask : tIrq

    initial begin
        resetn = 1'b0;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        datI = 32'h0;
        ev = 9'h000;
        clockOn = 1'b0;
        pin = 2'b00;
        drv = 2'b00;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        tRegs();
        tFlags();
        tMirror();
        tIrq();
        stopTest();
    end
endmodule : testbench
